// file: core/fesc_pkg.sv
// Shared constants, code-group tables and helpers for the symbol coding path
`default_nettype none
package fesc_pkg;
   // ==========================================================
   // Register map (word index on the plain register port)
   localparam logic [4:0] REG_CTRL = 5'h10;
   localparam logic [4:0] REG_STAT = 5'h11;
   localparam logic [15:0] CTRL_RST = 16'h0001;
   localparam int CTRL_SPEED100 = 0;
   localparam int CTRL_SYMBOL = 1;
   localparam int CTRL_TXINV = 2;
   localparam int STAT_INVALID = 7;
   localparam int STAT_HALT = 6;
   localparam int STAT_PREMATURE = 5;
   localparam int STAT_POLINV = 4;
   localparam logic [15:0] STAT_LH_MASK = 16'h00e0;
   // ==========================================================
   // Timing: cycles of mclk per bit (100 Mb) and per half bit (10 Mb)
   localparam logic [4:0] BIT_DIV_100 = 5'h02;
   localparam logic [4:0] MAN_HALF_DIV = 5'h0a;
   localparam logic [3:0] DSC_LOCK_BITS = 4'hb;
   localparam logic [2:0] POL_RUN = 3'h4;
   // Scrambler seed: upper bits fixed so the seed is never all zero
   localparam logic [5:0] SEED_HI = 6'h21;
   // ==========================================================
   // Code groups
   localparam logic [4:0] CG_IDLE = 5'h1f;
   localparam logic [4:0] CG_J = 5'h18;
   localparam logic [4:0] CG_K = 5'h11;
   localparam logic [4:0] CG_T = 5'h0d;
   localparam logic [4:0] CG_R = 5'h07;
   localparam logic [4:0] CG_HALT = 5'h04;
   localparam logic [4:0] CG_FORCED_INV = 5'h00;
   localparam logic [3:0] NIB_PREAMBLE = 4'h5;
   localparam logic [79:0] ENC_TABLE = 80'hef37_abda_727b_96aa_d13e;

   typedef enum logic [2:0] {CLS_DATA, CLS_IDLE, CLS_J, CLS_K, CLS_T, CLS_R, CLS_HALT, CLS_INV} fesc_cls_t;

   // Nibble to code group, entry 0 in the low five bits
   function automatic logic [4:0] fesc_encode(input logic [3:0] nib);
      logic [79:0] tab;
      tab = ENC_TABLE;
      fesc_encode = tab[5*nib +: 5];
   endfunction : fesc_encode

   // Code group to nibble; non-data groups return zero
   function automatic logic [3:0] fesc_decode(input logic [4:0] cg);
      logic [3:0] res;
      res = 4'h0;
      for (int i = 0; i < 16; i++)
      begin
         if (fesc_encode(4'(i)) == cg)
         begin
            res = 4'(i);
         end
      end
      fesc_decode = res;
   endfunction : fesc_decode

   function automatic fesc_cls_t fesc_classify(input logic [4:0] cg);
      fesc_cls_t c;
      c = CLS_INV;
      for (int i = 0; i < 16; i++)
      begin
         if (fesc_encode(4'(i)) == cg)
         begin
            c = CLS_DATA;
         end
      end
      case (cg)
         CG_IDLE: c = CLS_IDLE;
         CG_J: c = CLS_J;
         CG_K: c = CLS_K;
         CG_T: c = CLS_T;
         CG_R: c = CLS_R;
         CG_HALT: c = CLS_HALT;
         default: c = c;
      endcase
      fesc_classify = c;
   endfunction : fesc_classify
endpackage : fesc_pkg
`default_nettype wire

// file: core/fesc_lfsr.sv
// Eleven-bit cipher shift register shared by scrambler and descrambler
`default_nettype none
module fesc_lfsr
   import fesc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Control
   input wire logic load,
   input wire logic [10:0] seed,
   input wire logic step,
   input wire logic ext_en,
   input wire logic ext_bit,
   // Key stream
   output logic key
);
   logic [10:0] state;
   logic [10:0] next_state;

   // Feedback x^11 + x^9 + 1, or an external bit while training
   always_comb
   begin
      next_state = state;
      if (load)
      begin
         next_state = seed;
      end
      else if (step)
      begin
         next_state = {state[9:0], ext_en ? ext_bit : (state[10] ^ state[8])}; // R19
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= 11'h7ff;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Key is the bit about to enter, so a copy trained on past key bits predicts the next one
   assign key = state[10] ^ state[8]; // R19
endmodule : fesc_lfsr
`default_nettype wire

// file: core/fesc_path.sv
// 100 Mb symbol coding path: 4B/5B, cipher, NRZI, MLT-3 and polarity fix
`default_nettype none
// Contract
// [R1] Each data nibble maps to one of sixteen 5-bit groups; decoder inverts it.
// [R2] Six of the other groups are control groups; remaining ten are invalid.
// [R3] The halt group also marks a transmit error on the line.
// [R4] Stream start is J then K; stream end is T then R.
// [R5] An undefined received group sets the invalid-group status flag, bit 17.7.
// [R6] A received halt group sets the halt-detected status flag, bit 17.6.
// [R7] Test bit 16.2 plus MAC transmit error sends an invalid group.
// [R8] In 100 Mb mode transmit is scrambled and receive descrambled.
// [R9] Transmit scrambler seed comes from the device's own PHY address.
// [R10] Symbol interface mode bypasses scrambler and descrambler.
// [R11] Transmit NRZI stream becomes three-level code using -1, 0, +1.
// [R12] Receive three-level signal becomes NRZI again before decoding.
// [R13] Swapped receive pair is detected and inverted, in 10 Mb and autonegotiation.
// [R14] Transmit pair is Manchester at 10 Mb, three-level at 100 Mb.
// [R15] First two preamble nibbles become J K; T R appended after enable drops.
// [R16] Confirmed J K becomes two preamble nibbles; T R is not forwarded.
// [R17] Serialised transmit stream is NRZI coded before line coding.
// [R18] Code-group values follow the standard 4B/5B table.
// [R19] Cipher register is 11 bits, x^11 + x^9 + 1, XORed per bit.
// [R20] MLT-3 steps through 0, +1, 0, -1 on a one and holds on zero.
module fesc_path
   import fesc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Register port
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Straps and link state
   input wire logic [4:0] phy_addr,
   input wire logic autoneg_active,
   // MAC transmit side
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic [3:0] txd,
   output logic tx_nib_take,
   // MAC receive side
   output logic [3:0] rxd,
   output logic rx_dv,
   output logic rx_er,
   output logic rx_nib_valid,
   // Line
   output logic line_tx_positive,
   output logic line_tx_negative,
   input wire logic line_rx_positive,
   input wire logic line_rx_negative
);
   typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} fesc_tx_t;
   typedef enum {RX_IDLE, RX_PRE2, RX_DATA, RX_ESD} fesc_rx_t;

   // ==========================================================
   // Registers and bit-rate divider
   logic [15:0] ctrl, next_ctrl, stat, next_stat, next_rdata;
   logic [4:0] div, next_div;
   logic half_ph, next_half_ph, seeded, next_seeded;
   logic speed100, sym_mode, bit_en, half_en;
   logic set_inv, set_halt, set_prem, pol_inv;

   assign speed100 = ctrl[CTRL_SPEED100];
   assign sym_mode = ctrl[CTRL_SYMBOL];
   assign half_en = !speed100 && (div == MAN_HALF_DIV - 5'h01);
   assign bit_en = speed100 ? (div == BIT_DIV_100 - 5'h01) : (half_en && half_ph);

   // Latching status: a set in the reading cycle survives the clear
   always_comb
   begin
      next_ctrl = ctrl;
      next_rdata = 16'h0000;
      next_stat = stat;
      if (reg_wr && reg_addr == REG_CTRL)
      begin
         next_ctrl = reg_wdata & 16'h0007;
      end
      if (reg_rd && reg_addr == REG_CTRL)
      begin
         next_rdata = ctrl;
      end
      if (reg_rd && reg_addr == REG_STAT)
      begin
         next_rdata = stat;
         next_stat = stat & ~STAT_LH_MASK;
      end
      next_stat[STAT_INVALID] = next_stat[STAT_INVALID] | set_inv; // R5
      next_stat[STAT_HALT] = next_stat[STAT_HALT] | set_halt; // R6
      next_stat[STAT_PREMATURE] = next_stat[STAT_PREMATURE] | set_prem;
      next_stat[STAT_POLINV] = pol_inv;
      next_div = (bit_en || half_en || div == MAN_HALF_DIV - 5'h01) ? 5'h00 : div + 5'h01;
      next_half_ph = half_en ? !half_ph : half_ph;
      next_seeded = 1'b1;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl <= CTRL_RST;
         stat <= 16'h0000;
         reg_rdata <= 16'h0000;
         div <= 5'h00;
         half_ph <= 1'b0;
         seeded <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         stat <= next_stat;
         reg_rdata <= next_rdata;
         div <= next_div;
         half_ph <= next_half_ph;
         seeded <= next_seeded;
      end
   end

   // ==========================================================
   // Transmit: framing, 4B/5B, serialiser, cipher, NRZI, MLT-3
   fesc_tx_t tx_st, next_tx_st;
   logic [4:0] tx_sh, next_tx_sh, tx_code, next_tx_code, prev_code, next_prev_code;
   logic [2:0] tx_bcnt, next_tx_bcnt;
   logic [1:0] mlt_ph, next_mlt_ph;
   logic tx_nrzi, next_tx_nrzi, next_take, tx_key, tx_slot, tx_bit;
   logic next_ltp, next_ltn;

   assign tx_slot = bit_en && tx_bcnt == 3'h4;
   assign tx_bit = sym_mode ? tx_sh[4] : (tx_sh[4] ^ tx_key); // R8 R10

   // Scrambler seeded from the strapped address once, after reset release
   fesc_lfsr u_scr (
      .mclk(mclk),
      .arst_n(arst_n),
      .load(!seeded), // R9
      .seed({SEED_HI, phy_addr}),
      .step(bit_en && speed100),
      .ext_en(1'b0),
      .ext_bit(1'b0),
      .key(tx_key)
   );

   always_comb
   begin
      next_tx_st = tx_st;
      next_tx_code = tx_code;
      next_prev_code = prev_code;
      next_tx_sh = tx_sh;
      next_tx_bcnt = tx_bcnt;
      next_tx_nrzi = tx_nrzi;
      next_mlt_ph = mlt_ph;
      next_take = tx_slot;
      next_ltp = line_tx_positive;
      next_ltn = line_tx_negative;
      if (tx_slot)
      begin
         next_prev_code = tx_code;
         next_tx_bcnt = 3'h0;
         case (tx_st)
            TX_IDLE:
            begin
               next_tx_code = tx_en ? CG_J : CG_IDLE; // R4 R15
               next_tx_st = tx_en ? TX_K : TX_IDLE;
            end
            TX_K:
            begin
               next_tx_code = CG_K; // R4 R15
               next_tx_st = TX_DATA;
            end
            TX_DATA:
            begin
               if (!tx_en)
               begin
                  next_tx_code = CG_T; // R4 R15
                  next_tx_st = TX_R;
               end
               else if (tx_er)
               begin
                  next_tx_code = ctrl[CTRL_TXINV] ? CG_FORCED_INV : CG_HALT; // R3 R7
               end
               else
               begin
                  next_tx_code = fesc_encode(txd); // R1 R18
               end
            end
            TX_R:
            begin
               next_tx_code = CG_R; // R4
               next_tx_st = TX_IDLE;
            end
            default: next_tx_st = TX_IDLE;
         endcase
         if (sym_mode)
         begin
            next_tx_code = {tx_er, txd};
            next_tx_st = TX_IDLE;
         end
         next_tx_sh = next_tx_code;
      end
      else if (bit_en)
      begin
         next_tx_sh = {tx_sh[3:0], 1'b0};
         next_tx_bcnt = tx_bcnt + 3'h1;
      end
      if (bit_en && speed100)
      begin
         next_tx_nrzi = tx_nrzi ^ tx_bit; // R17
         next_mlt_ph = mlt_ph + {1'b0, next_tx_nrzi ^ tx_nrzi}; // R20
         next_ltp = next_mlt_ph == 2'h1; // R11 R14
         next_ltn = next_mlt_ph == 2'h3;
      end
      else if (half_en)
      begin
         // Two-level split phase; only the line coding of the 10 Mb path lives here
         next_ltp = half_ph ? !tx_sh[4] : tx_sh[4]; // R14
         next_ltn = !next_ltp;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_st <= TX_IDLE;
         tx_code <= CG_IDLE;
         prev_code <= CG_IDLE;
         tx_sh <= CG_IDLE;
         tx_bcnt <= 3'h0;
         tx_nrzi <= 1'b0;
         mlt_ph <= 2'h0;
         tx_nib_take <= 1'b0;
         line_tx_positive <= 1'b0;
         line_tx_negative <= 1'b0;
      end
      else
      begin
         tx_st <= next_tx_st;
         tx_code <= next_tx_code;
         prev_code <= next_prev_code;
         tx_sh <= next_tx_sh;
         tx_bcnt <= next_tx_bcnt;
         tx_nrzi <= next_tx_nrzi;
         mlt_ph <= next_mlt_ph;
         tx_nib_take <= next_take;
         line_tx_positive <= next_ltp;
         line_tx_negative <= next_ltn;
      end
   end

   // ==========================================================
   // Receive: synchroniser, polarity, MLT-3 and NRZI decode, cipher, framing
   logic [1:0] rxp_s, rxn_s;
   logic lp, ln, prev_lp, prev_ln, rx_nrzi, next_rx_nrzi, lvl_chg, raw_bit, dsc_key, dbit;
   logic next_pol_inv, next_rx_dv, next_rx_er, next_nib_v, slot;
   logic [2:0] neg_run, next_neg_run, rx_bcnt, next_rx_bcnt;
   logic [3:0] dsc_cnt, next_dsc_cnt, next_rxd;
   logic [9:0] rx_win, next_rx_win;
   fesc_rx_t rx_st, next_rx_st;
   fesc_cls_t cls;

   // Pins cross in through two flops; only the second is read
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rxp_s <= 2'h0;
         rxn_s <= 2'h0;
      end
      else
      begin
         rxp_s <= {rxp_s[0], line_rx_positive};
         rxn_s <= {rxn_s[0], line_rx_negative};
      end
   end

   assign lp = pol_inv ? rxn_s[1] : rxp_s[1]; // R13
   assign ln = pol_inv ? rxp_s[1] : rxn_s[1];
   assign lvl_chg = (lp != prev_lp) || (ln != prev_ln); // R12
   assign next_rx_nrzi = rx_nrzi ^ lvl_chg;
   assign raw_bit = next_rx_nrzi ^ rx_nrzi;
   assign dbit = sym_mode ? raw_bit : (dsc_cnt == DSC_LOCK_BITS ? raw_bit ^ dsc_key : 1'b1); // R8 R10
   assign next_rx_win = {rx_win[8:0], dbit};
   assign slot = rx_bcnt == 3'h4;
   assign cls = fesc_classify(next_rx_win[4:0]); // R2

   // Idle line is all ones, so the inverted ciphertext trains the key register
   fesc_lfsr u_dsc (
      .mclk(mclk),
      .arst_n(arst_n),
      .load(1'b0),
      .seed(11'h7ff),
      .step(bit_en && speed100),
      .ext_en(dsc_cnt != DSC_LOCK_BITS),
      .ext_bit(!raw_bit),
      .key(dsc_key)
   );

   always_comb
   begin
      next_pol_inv = pol_inv;
      next_neg_run = neg_run;
      next_dsc_cnt = dsc_cnt;
      next_rx_st = rx_st;
      next_rx_bcnt = rx_bcnt;
      next_rxd = rxd;
      next_rx_dv = rx_dv;
      next_rx_er = 1'b0;
      next_nib_v = 1'b0;
      set_inv = 1'b0;
      set_halt = 1'b0;
      set_prem = 1'b0;
      // A run of negative-going pulse starts means the pair is crossed
      if ((!speed100 || autoneg_active) && !prev_lp && !prev_ln && (lp || ln)) // R13
      begin
         next_neg_run = ln ? neg_run + 3'h1 : 3'h0;
         if (ln && neg_run == POL_RUN - 3'h1)
         begin
            next_pol_inv = !pol_inv;
            next_neg_run = 3'h0;
         end
      end
      if (bit_en && speed100)
      begin
         // Training counts from the first line change, so stale cable bits never end up in the key
         if (dsc_cnt != DSC_LOCK_BITS && (dsc_cnt != 4'h0 || lvl_chg))
         begin
            next_dsc_cnt = dsc_cnt + 4'h1;
         end
         next_rx_bcnt = slot ? 3'h0 : rx_bcnt + 3'h1;
         case (rx_st)
            RX_IDLE:
            begin
               next_rx_bcnt = 3'h0;
               if (next_rx_win == {CG_J, CG_K}) // R16
               begin
                  next_rxd = NIB_PREAMBLE;
                  next_nib_v = 1'b1;
                  next_rx_dv = 1'b1;
                  next_rx_st = RX_PRE2;
               end
            end
            RX_PRE2, RX_DATA:
            begin
               if (rx_st == RX_PRE2 && rx_bcnt == 3'h2)
               begin
                  next_rxd = NIB_PREAMBLE; // R16
                  next_nib_v = 1'b1;
                  next_rx_st = RX_DATA;
               end
               if (slot)
               begin
                  next_rx_st = RX_DATA;
                  case (cls)
                     CLS_DATA:
                     begin
                        next_rxd = fesc_decode(next_rx_win[4:0]); // R1
                        next_nib_v = 1'b1;
                     end
                     CLS_T:
                     begin
                        next_rx_dv = 1'b0; // R16
                        next_rx_st = RX_ESD;
                     end
                     CLS_IDLE:
                     begin
                        next_rx_er = 1'b1;
                        set_prem = 1'b1;
                        next_rx_dv = 1'b0;
                        next_rx_st = RX_IDLE;
                     end
                     default:
                     begin
                        next_rx_er = 1'b1;
                        next_nib_v = 1'b1;
                     end
                  endcase
               end
            end
            RX_ESD:
            begin
               if (slot)
               begin
                  next_rx_er = cls != CLS_R;
                  next_rx_st = RX_IDLE;
               end
            end
            default: next_rx_st = RX_IDLE;
         endcase
         if (slot && rx_st != RX_IDLE)
         begin
            set_inv = cls == CLS_INV; // R5
            set_halt = cls == CLS_HALT; // R6
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prev_lp <= 1'b0;
         prev_ln <= 1'b0;
         rx_nrzi <= 1'b0;
         pol_inv <= 1'b0;
         neg_run <= 3'h0;
         dsc_cnt <= 4'h0;
         rx_win <= 10'h3ff;
         rx_st <= RX_IDLE;
         rx_bcnt <= 3'h0;
         rxd <= 4'h0;
         rx_dv <= 1'b0;
         rx_er <= 1'b0;
         rx_nib_valid <= 1'b0;
      end
      else
      begin
         prev_lp <= lp;
         prev_ln <= ln;
         pol_inv <= next_pol_inv;
         neg_run <= next_neg_run;
         rx_nib_valid <= next_nib_v;
         rx_er <= next_rx_er;
         if (bit_en && speed100)
         begin
            rx_nrzi <= next_rx_nrzi;
            dsc_cnt <= next_dsc_cnt;
            rx_win <= next_rx_win;
         end
         rx_st <= next_rx_st;
         rx_bcnt <= next_rx_bcnt;
         rxd <= next_rxd;
         rx_dv <= next_rx_dv;
      end
   end

   // ==========================================================
   // Checks
   sequence tx_load_s(logic [4:0] cg);
      tx_slot ##1 tx_code == cg;
   endsequence

   start_pair_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
      tx_slot && !sym_mode ##1 prev_code == CG_J |-> tx_code == CG_K)
      else $error("J not followed by K");
   end_pair_a: assert property (@(posedge mclk) disable iff (!arst_n) // R15
      tx_slot && !sym_mode ##1 prev_code == CG_T |-> tx_code == CG_R)
      else $error("T not followed by R");
   tx_error_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
      tx_slot && tx_st == TX_DATA && tx_en && tx_er && !sym_mode |-> ##1 tx_code == (ctrl[CTRL_TXINV] ? CG_FORCED_INV : CG_HALT))
      else $error("transmit error group wrong");
   data_code_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
      tx_slot && tx_st == TX_DATA && tx_en && !tx_er && !sym_mode |-> ##1 tx_code == fesc_encode($past(txd)))
      else $error("data group wrong");
   mlt_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R20
      bit_en && speed100 && !tx_bit |=> $stable(mlt_ph))
      else $error("MLT-3 moved on zero");
   mlt_step_a: assert property (@(posedge mclk) disable iff (!arst_n) // R11
      bit_en && speed100 && tx_bit |=> mlt_ph == $past(mlt_ph) + 2'h1 ##1 !(line_tx_positive && line_tx_negative))
      else $error("MLT-3 did not advance");
   inv_flag_a: assert property (@(posedge mclk) disable iff (!arst_n) // R5
      set_inv |=> stat[STAT_INVALID] ##1 stat[STAT_INVALID] || $past(reg_rd && reg_addr == REG_STAT))
      else $error("invalid flag not latched");
   halt_flag_a: assert property (@(posedge mclk) disable iff (!arst_n) // R6
      set_halt |=> stat[STAT_HALT])
      else $error("halt flag not latched");
   preamble_a: assert property (@(posedge mclk) disable iff (!arst_n) // R16
      rx_st == RX_IDLE && next_rx_st == RX_PRE2 |=> rx_dv && rx_nib_valid && rxd == NIB_PREAMBLE ##[1:20] rx_nib_valid)
      else $error("start pair not replaced");
   pol_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R13
      speed100 && !autoneg_active |=> $stable(pol_inv))
      else $error("polarity moved outside 10 Mb or negotiation");
endmodule : fesc_path
`default_nettype wire

// file: tb/fesc_link_model.sv
// Line-side partner: a wired loopback of the transmit pair with cable delay
`default_nettype none
module fesc_link_model
#(
   parameter int DLY = 3
)
(
   // Clock
   input wire logic mclk,
   // Pair from the device
   input wire logic tx_p,
   input wire logic tx_n,
   // Pair back to the device
   output logic rx_p,
   output logic rx_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2*DLY-1:0] pipe = '0;
   // ====
   // Cable delay; a larger DLY models a slow, distant partner
   always @(posedge mclk)
   begin
      pipe <= {pipe[2*DLY-3:0], tx_p, tx_n};
   end
   assign rx_p = pipe[2*DLY-1];
   assign rx_n = pipe[2*DLY-2];
endmodule : fesc_link_model
`default_nettype wire

// file: tb/tb_fesc_path.sv
// Self-checking bench for the symbol coding path in loopback
`default_nettype none
module tb_fesc_path
   import fesc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic tx_en = 1'b0;
   logic tx_er = 1'b0;
   logic [3:0] txd = 4'h0;
   logic tx_nib_take, rx_dv, rx_er, rx_nib_valid, ltp, ltn, lrp, lrn;
   logic [3:0] rxd;
   logic [1:0] prev = 2'h0;
   logic rd_d = 1'b0;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int chg = 0;
   int er_seen = 0;
   int c0;
   logic [15:0] exp_q[$];
   logic [15:0] reg_q[$];
   logic [15:0] msk_q[$];

   // ====
   // Design and its line partner
   fesc_path DUT (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phy_addr(5'h0b),
      .autoneg_active(1'b0), .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .tx_nib_take(tx_nib_take),
      .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .rx_nib_valid(rx_nib_valid),
      .line_tx_positive(ltp), .line_tx_negative(ltn), .line_rx_positive(lrp), .line_rx_negative(lrn));
   fesc_link_model #(.DLY(3)) partner (.mclk(mclk), .tx_p(ltp), .tx_n(ltn), .rx_p(lrp), .rx_n(lrn));

   always #2.5 mclk = ~mclk;

   // ====
   // Comparison and closing
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : report_and_stop

   // Cut a hang short well past the expected run length
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_total++;
         report_and_stop();
      end
   end

   // ====
   // Output watcher: takes the oldest note whenever a result shows
   always @(posedge mclk)
   begin
      rd_d <= reg_rd;
      prev <= {ltp, ltn};
      if ({ltp, ltn} != prev)
         chg <= chg + 1;
      if (rx_er)
         er_seen <= er_seen + 1;
      if (rd_d)
         check("reg_rdata", reg_rdata & msk_q.pop_front(), reg_q.pop_front());
      if (rx_nib_valid && !rx_er)
      begin
         check("rxd", {12'h000, rxd}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hffff);
         check("rx_dv", {15'h0000, rx_dv}, 16'h0001);
      end
   end

   // ====
   // Register port and MAC transmit drivers
   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : reg_write

   task automatic reg_read(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
      reg_q.push_back(e);
      msk_q.push_back(m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask : reg_read

   // Hold the nibble until the design shows it was sampled
   task automatic send(input logic en, input logic er, input logic [3:0] d);
      tx_en <= en;
      tx_er <= er;
      txd <= d;
      // A pulse at the first edge answers a sample taken before these values
      @(posedge mclk);
      do @(posedge mclk); while (tx_nib_take !== 1'b1);
   endtask : send

   // Preamble pair, random data with an optional error nibble, then end
   task automatic frame(input int n, input int bad);
      logic [3:0] d;
      exp_q.push_back(16'h0005);
      exp_q.push_back(16'h0005);
      send(1'b1, 1'b0, NIB_PREAMBLE);
      send(1'b1, 1'b0, NIB_PREAMBLE);
      for (int i = 0; i < n; i++)
      begin
         d = 4'($urandom);
         if (i != bad)
            exp_q.push_back({12'h000, d});
         send(1'b1, i == bad, d);
      end
      // Error with enable low must be ignored; T and R must not reach the MAC
      repeat (4) send(1'b0, 1'b1, 4'h0);
      $display("test frame done");
   endtask : frame

   // ====
   // Main sequence
   initial
   begin
      void'($urandom(21));
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      reg_read(REG_CTRL, CTRL_RST, 16'hffff);
      reg_write(REG_CTRL, 16'hfff9);
      reg_write(5'h03, 16'hffff);
      reg_read(REG_CTRL, 16'h0001, 16'hffff);
      reg_read(5'h03, 16'h0000, 16'hffff);
      $display("test registers done");
      // Long idle so the receive cipher locks before traffic
      repeat (100) @(posedge mclk);
      frame(16, 99);
      reg_read(REG_STAT, 16'h0000, 16'h00f0);
      check("rx_er count", 16'(er_seen), 16'h0000);
      check("rx_dv after end", {15'h0000, rx_dv}, 16'h0000);
      frame(12, 5);
      reg_read(REG_STAT, 16'h0040, 16'h00f0);
      check("rx_er count", 16'(er_seen), 16'h0001);
      reg_read(REG_STAT, 16'h0000, 16'h00f0);
      reg_write(REG_CTRL, 16'h0005);
      frame(12, 0);
      reg_read(REG_STAT, 16'h0080, 16'h00f0);
      check("rx_er count", 16'(er_seen), 16'h0002);
      // Symbol mode sends raw ones unciphered: one line step per bit
      reg_write(REG_CTRL, 16'h0003);
      tx_en <= 1'b1;
      tx_er <= 1'b1;
      txd <= 4'hf;
      repeat (20) @(posedge mclk);
      c0 = chg;
      repeat (40) @(posedge mclk);
      check("line steps", 16'(chg - c0), 16'h0014);
      $display("test symbol mode done");
      // Slow speed drives a split-phase pair
      reg_write(REG_CTRL, 16'h0000);
      repeat (20) @(posedge mclk);
      repeat (8)
      begin
         @(posedge mclk);
         check("split phase", {15'h0000, ltp ^ ltn}, 16'h0001);
      end
      $display("test slow speed done");
      check("notes left", 16'(exp_q.size()), 16'h0000);
      report_and_stop();
   end
endmodule : tb_fesc_path
`default_nettype wire
